/* hdl/pitp_pkg.sv */
/*
 * Shared constants and types of the regulator's two-wire target port.
 * Assumes one link-side sampling clock and one system clock, unrelated in phase.
 */
package pitp_pkg;

    // Factory address window
    localparam logic [6:0] TARGET_ADDR_MIN = 7'h18;
    localparam logic [6:0] TARGET_ADDR_MAX = 7'h1F;

    // High-speed entry code; only the upper five bits identify it
    localparam logic [7:0] HS_MASTER_CODE = 8'h08;

    // Bus rates in kb/s and the least sampling ratio the link logic needs
    localparam int FM_RATE_KBPS = 400;
    localparam int HS_RATE_KBPS = 3400;
    localparam int LINK_SAMPLES_MIN = 6;
    localparam int LINK_CLK_KHZ_DEF = 20833;

    // Bit counter layout
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;

    // Register access carried from the link side to the system side
    typedef struct packed {
        logic wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } pitp_req_s;

    // Link engine states
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_ADDR = 3'b001,
        ST_RX = 3'b010,
        ST_ACK = 3'b011,
        ST_TX = 3'b100,
        ST_TXACK = 3'b101,
        ST_WAIT = 3'b110
    } pitp_state_e;

endpackage

/* hdl/pitp_sync.sv */
/*
 * Two-flop synchroniser for levels and toggles entering a clock domain.
 * Assumes the input changes no faster than the destination clock can see.
 */
module pitp_sync
    import pitp_pkg::*;
#(
    parameter int W = 1
)
(
    input wire logic clk, // Destination clock
    input wire logic resetn, // Asynchronous reset, active low
    input wire logic [W-1:0] d, // Foreign-domain input
    output logic [W-1:0] q // Synchronised output
);

    logic [W-1:0] meta_reg;
    logic [W-1:0] q_reg;

    // First stage is read only by the second
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            meta_reg <= '0;
            q_reg <= '0;
        end
        else
        begin
            meta_reg <= d;
            q_reg <= meta_reg;
        end
    end

    assign q = q_reg;

endmodule

/* hdl/pitp_target.sv */
/*
 * Two-wire target port of the regulator: decodes bus transfers on the link clock
 * and hands register reads and writes to the system clock domain.
 * Assumes an open-drain bus resolved outside, a register file answering reg_ack.
 */
// Contract
// - Ignore accesses until supply and boot are ready
// - Answer only the fixed factory address
// - Serve fast-mode bit rates up to 400kb/s
// - Master code 08H selects high-speed mode
// - Never acknowledge the master code
// - Stream any number of bytes both ways
module pitp_target
    import pitp_pkg::*;
#(
    parameter logic [6:0] TARGET_ADDR = TARGET_ADDR_MIN,
    parameter int LINK_CLK_KHZ = LINK_CLK_KHZ_DEF
)
(
    input wire logic clk_sys, // System clock, 20 MHz
    input wire logic resetn, // Asynchronous reset, active low
    input wire logic ce, // System-side clock enable
    input wire logic clk_link, // Bus sampling clock
    input wire logic scl_in, // Bus clock level
    output logic scl_out, // Bus clock drive value, always low
    output logic scl_oe, // Holds bus clock low while stretching
    input wire logic sda_in, // Bus data level
    output logic sda_out, // Bus data drive value, always low
    output logic sda_oe, // Pulls bus data low
    input wire logic io_logic_supply_ok, // I/O logic supply valid
    input wire logic boot_done, // Converter boot finished
    output logic reg_req, // Register access pending
    output pitp_req_s reg_cmd, // Access kind, address, write data
    input wire logic reg_ack, // Register file done, one cycle
    input wire logic [7:0] reg_rdata, // Read data with reg_ack
    output logic hs_active // High-speed mode armed
);

    // Factory address and sampling ratio checked at elaboration
    if (TARGET_ADDR < TARGET_ADDR_MIN || TARGET_ADDR > TARGET_ADDR_MAX)
    begin : g_addr_chk
        $error("target address outside factory window");
    end
    if (LINK_CLK_KHZ < LINK_SAMPLES_MIN * HS_RATE_KBPS || HS_RATE_KBPS < FM_RATE_KBPS)
    begin : g_rate_chk
        $error("link clock too slow for high-speed sampling");
    end

    function automatic pitp_req_s mk_req(input logic wr, input logic [7:0] addr, input logic [7:0] data);
        pitp_req_s r;
        r.wr = wr;
        r.addr = addr;
        r.wdata = data;
        return r;
    endfunction

    // Link domain state
    pitp_state_e state_reg, state_next;
    logic [3:0] cnt_reg, cnt_next;
    logic [7:0] shift_reg, shift_next;
    logic [7:0] ptr_reg, ptr_next;
    logic rd_reg, rd_next;
    logic first_reg, first_next;
    logic ackdrv_reg, ackdrv_next;
    logic hs_reg, hs_next;
    logic mnack_reg, mnack_next;
    logic sda_oe_reg, sda_oe_next;
    logic scl_oe_reg, scl_oe_next;
    logic req_tgl_reg, req_tgl_next;
    logic ack_seen_reg, ack_seen_next;
    pitp_req_s hold_reg, hold_next;
    logic scl_d_reg, sda_d_reg;

    // System domain state
    logic busy_reg, busy_next;
    logic req_seen_reg, req_seen_next;
    logic ack_tgl_reg, ack_tgl_next;
    logic [7:0] rdata_reg, rdata_next;
    pitp_req_s cmd_reg, cmd_next;

    logic [3:0] pins_s;
    logic scl_s, sda_s, ready_s, ack_s, req_s;
    logic scl_rise, scl_fall, start_ev, stop_ev, ans_ev, byte_done;

    // Pins enter the link domain through two flops
    pitp_sync #(.W(4)) u_pin_sync (
        .clk(clk_link),
        .resetn(resetn),
        .d({scl_in, sda_in, io_logic_supply_ok, boot_done}),
        .q(pins_s)
    );
    pitp_sync #(.W(1)) u_ack_sync (
        .clk(clk_link),
        .resetn(resetn),
        .d(ack_tgl_reg),
        .q(ack_s)
    );
    pitp_sync #(.W(1)) u_req_sync (
        .clk(clk_sys),
        .resetn(resetn),
        .d(req_tgl_reg),
        .q(req_s)
    );
    pitp_sync #(.W(1)) u_hs_sync (
        .clk(clk_sys),
        .resetn(resetn),
        .d(hs_reg),
        .q(hs_active)
    );

    // Bus events from synchronised levels
    assign scl_s = pins_s[3];
    assign sda_s = pins_s[2];
    assign ready_s = pins_s[1] & pins_s[0];
    assign scl_rise = scl_s & ~scl_d_reg;
    assign scl_fall = ~scl_s & scl_d_reg;
    assign start_ev = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
    assign stop_ev = scl_s & scl_d_reg & ~sda_d_reg & sda_s;
    assign ans_ev = ack_s ^ ack_seen_reg;
    assign byte_done = scl_fall && cnt_reg == BITS_PER_BYTE;

    // Link engine next state; SDA only moves while SCL is low
    always_comb
    begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        shift_next = shift_reg;
        ptr_next = ptr_reg;
        rd_next = rd_reg;
        first_next = first_reg;
        ackdrv_next = ackdrv_reg;
        hs_next = hs_reg;
        mnack_next = mnack_reg;
        sda_oe_next = sda_oe_reg;
        scl_oe_next = scl_oe_reg;
        req_tgl_next = req_tgl_reg;
        ack_seen_next = ack_seen_reg;
        hold_next = hold_reg;
        if (ans_ev)
        begin
            ack_seen_next = ~ack_seen_reg;
        end
        if (stop_ev)
        begin
            state_next = ST_IDLE;
            hs_next = 1'b0;
            sda_oe_next = 1'b0;
            scl_oe_next = 1'b0;
        end
        else if (start_ev)
        begin
            state_next = ST_ADDR;
            cnt_next = 4'h0;
            sda_oe_next = 1'b0;
        end
        else
        begin
            unique case (state_reg)
                ST_IDLE:
                begin
                    sda_oe_next = 1'b0;
                end
                ST_ADDR, ST_RX:
                begin
                    if (scl_rise)
                    begin
                        shift_next = {shift_reg[6:0], sda_s};
                        cnt_next = cnt_reg + 4'h1;
                    end
                    else if (byte_done)
                    begin
                        cnt_next = 4'h0;
                        state_next = ST_IDLE;
                        if (state_reg == ST_ADDR && shift_reg[7:3] == HS_MASTER_CODE[7:3])
                        begin
                            hs_next = 1'b1;
                        end
                        else if (state_reg == ST_ADDR && shift_reg[7:1] == TARGET_ADDR && ready_s)
                        begin
                            sda_oe_next = 1'b1;
                            rd_next = shift_reg[0];
                            first_next = ~shift_reg[0];
                            state_next = ST_ACK;
                            if (shift_reg[0])
                            begin
                                hold_next = mk_req(1'b0, ptr_reg, 8'h00);
                                req_tgl_next = ~req_tgl_reg;
                                ackdrv_next = 1'b1;
                                scl_oe_next = 1'b1;
                                state_next = ST_WAIT;
                            end
                        end
                        else if (state_reg == ST_RX && ready_s)
                        begin
                            sda_oe_next = 1'b1;
                            state_next = ST_ACK;
                            if (first_reg)
                            begin
                                ptr_next = shift_reg;
                                first_next = 1'b0;
                            end
                            else
                            begin
                                hold_next = mk_req(1'b1, ptr_reg, shift_reg);
                                req_tgl_next = ~req_tgl_reg;
                                ackdrv_next = 1'b1;
                                scl_oe_next = 1'b1;
                                state_next = ST_WAIT;
                            end
                        end
                    end
                end
                ST_ACK:
                begin
                    if (scl_fall)
                    begin
                        cnt_next = rd_reg ? 4'h1 : 4'h0;
                        sda_oe_next = rd_reg & ~shift_reg[7];
                        state_next = rd_reg ? ST_TX : ST_RX;
                    end
                end
                ST_TX:
                begin
                    if (scl_fall)
                    begin
                        if (cnt_reg == BITS_PER_BYTE)
                        begin
                            sda_oe_next = 1'b0;
                            cnt_next = 4'h0;
                            state_next = ST_TXACK;
                        end
                        else
                        begin
                            shift_next = {shift_reg[6:0], 1'b0};
                            sda_oe_next = ~shift_reg[6];
                            cnt_next = cnt_reg + 4'h1;
                        end
                    end
                end
                ST_TXACK:
                begin
                    if (scl_rise)
                    begin
                        mnack_next = sda_s;
                    end
                    else if (scl_fall)
                    begin
                        state_next = ST_IDLE;
                        if (!mnack_reg && ready_s)
                        begin
                            hold_next = mk_req(1'b0, ptr_reg, 8'h00);
                            req_tgl_next = ~req_tgl_reg;
                            ackdrv_next = 1'b0;
                            scl_oe_next = 1'b1;
                            state_next = ST_WAIT;
                        end
                    end
                end
                ST_WAIT:
                begin
                    // Clock held low until the system side answers
                    if (ans_ev)
                    begin
                        scl_oe_next = 1'b0;
                        ptr_next = ptr_reg + 8'h01;
                        if (rd_reg)
                        begin
                            shift_next = rdata_reg;
                        end
                        if (ackdrv_reg)
                        begin
                            state_next = ST_ACK;
                        end
                        else
                        begin
                            sda_oe_next = ~rdata_reg[7];
                            cnt_next = 4'h1;
                            state_next = ST_TX;
                        end
                    end
                end
                default:
                begin
                    state_next = ST_IDLE;
                end
            endcase
        end
    end

    // Link registers
    always_ff @(posedge clk_link or negedge resetn)
    begin
        if (!resetn)
        begin
            state_reg <= ST_IDLE;
            cnt_reg <= 4'h0;
            shift_reg <= 8'h00;
            ptr_reg <= 8'h00;
            rd_reg <= 1'b0;
            first_reg <= 1'b0;
            ackdrv_reg <= 1'b0;
            hs_reg <= 1'b0;
            mnack_reg <= 1'b0;
            sda_oe_reg <= 1'b0;
            scl_oe_reg <= 1'b0;
            req_tgl_reg <= 1'b0;
            ack_seen_reg <= 1'b0;
            hold_reg <= '0;
            scl_d_reg <= 1'b1;
            sda_d_reg <= 1'b1;
        end
        else
        begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            shift_reg <= shift_next;
            ptr_reg <= ptr_next;
            rd_reg <= rd_next;
            first_reg <= first_next;
            ackdrv_reg <= ackdrv_next;
            hs_reg <= hs_next;
            mnack_reg <= mnack_next;
            sda_oe_reg <= sda_oe_next;
            scl_oe_reg <= scl_oe_next;
            req_tgl_reg <= req_tgl_next;
            ack_seen_reg <= ack_seen_next;
            hold_reg <= hold_next;
            scl_d_reg <= scl_s;
            sda_d_reg <= sda_s;
        end
    end

    // System side: take the held request, answer by toggle
    always_comb
    begin
        busy_next = busy_reg;
        req_seen_next = req_seen_reg;
        ack_tgl_next = ack_tgl_reg;
        rdata_next = rdata_reg;
        cmd_next = cmd_reg;
        if (ce)
        begin
            if (busy_reg && reg_ack)
            begin
                busy_next = 1'b0;
                rdata_next = reg_rdata;
                ack_tgl_next = ~ack_tgl_reg;
            end
            else if (!busy_reg && (req_s ^ req_seen_reg))
            begin
                // Held word is stable: the link waits for the answer
                busy_next = 1'b1;
                req_seen_next = ~req_seen_reg;
                cmd_next = hold_reg;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            busy_reg <= 1'b0;
            req_seen_reg <= 1'b0;
            ack_tgl_reg <= 1'b0;
            rdata_reg <= 8'h00;
            cmd_reg <= '0;
        end
        else
        begin
            busy_reg <= busy_next;
            req_seen_reg <= req_seen_next;
            ack_tgl_reg <= ack_tgl_next;
            rdata_reg <= rdata_next;
            cmd_reg <= cmd_next;
        end
    end

    // Open-drain drive: value is always low, enables select
    assign scl_out = 1'b0;
    assign sda_out = 1'b0;
    assign scl_oe = scl_oe_reg;
    assign sda_oe = sda_oe_reg;
    assign reg_req = busy_reg;
    assign reg_cmd = cmd_reg;

    sequence s_code_byte;
        state_reg == ST_ADDR && byte_done && shift_reg[7:3] == HS_MASTER_CODE[7:3];
    endsequence
    sequence s_read_more;
        state_reg == ST_TXACK && scl_fall && !mnack_reg && ready_s && !stop_ev && !start_ev;
    endsequence

    a_gate_ready: assert property (@(posedge clk_link) disable iff (!resetn)
        (state_reg == ST_ADDR && byte_done && !ready_s && !start_ev && !stop_ev) |=> !sda_oe_reg && state_reg == ST_IDLE)
        else $error("address acknowledged while not ready");
    a_addr_match: assert property (@(posedge clk_link) disable iff (!resetn)
        (state_reg == ST_ADDR && byte_done && shift_reg[7:1] != TARGET_ADDR) |=> !sda_oe_reg)
        else $error("foreign address acknowledged");
    a_stretch_end: assert property (@(posedge clk_link) disable iff (!resetn)
        (state_reg == ST_WAIT && ans_ev && !start_ev && !stop_ev) |=> !scl_oe_reg && state_reg != ST_WAIT)
        else $error("clock stretch not released after answer");
    a_hs_enter: assert property (@(posedge clk_link) disable iff (!resetn)
        s_code_byte ##0 (!start_ev && !stop_ev) |=> hs_reg && state_reg == ST_IDLE)
        else $error("master code did not arm high-speed mode");
    a_code_nack: assert property (@(posedge clk_link) disable iff (!resetn)
        s_code_byte |=> !sda_oe_reg [*2])
        else $error("master code acknowledged");
    a_read_next: assert property (@(posedge clk_link) disable iff (!resetn)
        s_read_more |=> state_reg == ST_WAIT && scl_oe_reg && $changed(req_tgl_reg))
        else $error("no fetch after controller acknowledge");
    a_req_held: assert property (@(posedge clk_sys) disable iff (!resetn)
        (reg_req && !(ce && reg_ack)) |=> reg_req && $stable(reg_cmd))
        else $error("pending access dropped or changed");
    a_stop_fs: assert property (@(posedge clk_link) disable iff (!resetn)
        stop_ev |=> !hs_reg && state_reg == ST_IDLE && !scl_oe_reg)
        else $error("high-speed mode kept after stop");

endmodule

/* sim/pitp_ctrl_model.sv */
/*
 * Two-wire bus controller model that drives the target port from outside.
 * Assumes the bench resolves both open-drain wires with pull-ups.
 */
module pitp_ctrl_model
(
    input wire logic clk_sys, // Timing reference, changes land on its falling edge
    input wire logic scl, // Resolved bus clock
    input wire logic sda, // Resolved bus data
    output logic scl_low, // Pulls bus clock low
    output logic sda_low // Pulls bus data low
);
    timeunit 1ns;
    timeprecision 1ps;
    int t_lo = 26;
    int t_hi = 24;
    int stalls = 0;

    // Both wires released at time zero
    initial
    begin
        scl_low = 1'b0;
        sda_low = 1'b0;
    end

    // Fast mode 2.5 us a bit; high-speed 350 ns a bit, low phase long enough for sampling
    task automatic set_speed(input bit hs);
        t_lo = hs ? 5 : 26;
        t_hi = hs ? 2 : 24;
    endtask

    task automatic wait_n(input int n);
        repeat (n) @(negedge clk_sys);
    endtask

    // Release clock and honour stretching, but never wait forever
    task automatic rise_scl();
        int k;
        k = 0;
        scl_low = 1'b0;
        do
        begin
            @(negedge clk_sys);
            k++;
        end
        while (scl !== 1'b1 && k < 4000);
        if (k >= 4000)
            stalls++;
        wait_n(t_hi);
    endtask

    // Data moves one cycle after the clock fall so it is never mistaken for a condition
    task automatic bit_io(input bit b, output logic s);
        wait_n(1);
        sda_low = ~b;
        wait_n(t_lo);
        rise_scl();
        s = sda;
        scl_low = 1'b1;
    endtask

    // Serves as repeated start too
    task automatic start_cond();
        wait_n(1);
        sda_low = 1'b0;
        wait_n(t_lo);
        rise_scl();
        sda_low = 1'b1;
        wait_n(t_hi);
        scl_low = 1'b1;
    endtask

    task automatic stop_cond();
        wait_n(1);
        sda_low = 1'b1;
        wait_n(t_lo);
        rise_scl();
        sda_low = 1'b0;
        wait_n(t_hi);
    endtask

    // MSB first, returns true on acknowledge
    task automatic send_byte(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--)
            bit_io(d[i], s);
        bit_io(1'b1, s);
        ack = ~s;
    endtask

    // Acknowledge asks for more, not-acknowledge ends the read
    task automatic recv_byte(input bit ack, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--)
        begin
            bit_io(1'b1, s);
            d[i] = s;
        end
        bit_io(~ack, s);
    endtask
endmodule

/* sim/pitp_target_tb_top.sv */
/*
 * Self-checking bench of the two-wire target port with a register file stand-in.
 * Assumes pull-ups on both wires and a free-running link sampling clock.
 */
module pitp_target_tb_top
    import pitp_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [6:0] DUT_ADDR = 7'h1B;
    logic clk_sys, clk_link, resetn, io_logic_supply_ok, boot_done, reg_ack, reg_req, hs_active;
    logic scl_oe, scl_out, sda_oe, sda_out, scl_low, sda_low;
    logic [7:0] reg_rdata;
    logic [7:0] mem [256];
    pitp_req_s reg_cmd;
    wire scl;
    wire sda;
    int n_acc = 0;
    int errors = 0;
    int cmp_count = 0;

    // Wired-AND of all drivers, pull-up when nobody pulls
    assign scl = (scl_oe ? scl_out : 1'b1) & ~scl_low;
    assign sda = (sda_oe ? sda_out : 1'b1) & ~sda_low;

    pitp_target #(.TARGET_ADDR(DUT_ADDR)) i_pitp_target (.clk_sys(clk_sys), .resetn(resetn), .ce(1'b1),
        .clk_link(clk_link), .scl_in(scl), .scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda), .sda_out(sda_out),
        .sda_oe(sda_oe), .io_logic_supply_ok(io_logic_supply_ok), .boot_done(boot_done), .reg_req(reg_req),
        .reg_cmd(reg_cmd), .reg_ack(reg_ack), .reg_rdata(reg_rdata), .hs_active(hs_active));
    pitp_ctrl_model i_pitp_ctrl_model (.clk_sys(clk_sys), .scl(scl), .sda(sda), .scl_low(scl_low),
        .sda_low(sda_low));

    // Unrelated clocks: 50 ns system, 48 ns link
    initial
    begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end
    initial
    begin
        clk_link = 1'b0;
        #7;
        forever #24 clk_link = ~clk_link;
    end

    // Register file stand-in, answers two cycles late; read data is junk outside the ack
    initial
    begin
        reg_ack = 1'b0;
        reg_rdata = 8'h00;
        forever
        begin
            @(negedge clk_sys);
            if (reg_req === 1'b1)
            begin
                repeat (2) @(negedge clk_sys);
                reg_ack = 1'b1;
                n_acc++;
                if (reg_cmd.wr)
                    mem[reg_cmd.addr] = reg_cmd.wdata;
                else
                    reg_rdata = mem[reg_cmd.addr];
                @(negedge clk_sys);
                reg_ack = 1'b0;
                reg_rdata = ~reg_rdata;
            end
        end
    end

    task automatic chk_bit(input string what, input logic exp, input logic got);
        cmp_count++;
        if (got !== exp)
        begin
            errors++;
            $display("unexpected %s expected %b seen %b", what, exp, got);
        end
    endtask

    task automatic chk_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
        cmp_count++;
        if (got !== exp)
        begin
            errors++;
            $display("unexpected %s expected %h seen %h", what, exp, got);
        end
    endtask

    // One byte that the target must acknowledge
    task automatic put(input logic [7:0] d);
        logic ack;
        i_pitp_ctrl_model.send_byte(d, ack);
        chk_bit("byte ack", 1'b1, ack);
    endtask

    task automatic t_not_ready();
        logic ack;
        int n0;
        n0 = n_acc;
        for (int k = 0; k < 2; k++)
        begin
            io_logic_supply_ok = k[0];
            boot_done = ~k[0];
            i_pitp_ctrl_model.start_cond();
            i_pitp_ctrl_model.send_byte({DUT_ADDR, 1'b0}, ack);
            chk_bit("addr ack not ready", 1'b0, ack);
            i_pitp_ctrl_model.stop_cond();
        end
        // Ready for the address, then boot drops before the data byte
        io_logic_supply_ok = 1'b1;
        boot_done = 1'b1;
        i_pitp_ctrl_model.start_cond();
        put({DUT_ADDR, 1'b0});
        boot_done = 1'b0;
        i_pitp_ctrl_model.send_byte(8'h40, ack);
        chk_bit("data ack not ready", 1'b0, ack);
        i_pitp_ctrl_model.stop_cond();
        chk_byte("accesses not ready", 8'(n0), 8'(n_acc));
        boot_done = 1'b1;
        $display("test not_ready done");
    endtask

    task automatic t_addr_range();
        logic ack;
        for (int a = 24; a <= 31; a++)
        begin
            i_pitp_ctrl_model.start_cond();
            i_pitp_ctrl_model.send_byte({7'(a), 1'b0}, ack);
            chk_bit("addr ack", 7'(a) == DUT_ADDR, ack);
            i_pitp_ctrl_model.stop_cond();
        end
        $display("test addr_range done");
    endtask

    task automatic t_write_stream();
        int n0;
        n0 = n_acc;
        i_pitp_ctrl_model.start_cond();
        put({DUT_ADDR, 1'b0});
        put(8'h40);
        put(8'h5A);
        put(8'hC3);
        put(8'h0F);
        i_pitp_ctrl_model.stop_cond();
        chk_byte("mem 40", 8'h5A, mem[8'h40]);
        chk_byte("mem 41", 8'hC3, mem[8'h41]);
        chk_byte("mem 42", 8'h0F, mem[8'h42]);
        chk_byte("write accesses", 8'(n0 + 3), 8'(n_acc));
        $display("test write_stream done");
    endtask

    // Pointer set, repeated start, three reads ending in not-acknowledge
    task automatic t_read_stream();
        logic [7:0] d;
        int n0;
        n0 = n_acc;
        i_pitp_ctrl_model.start_cond();
        put({DUT_ADDR, 1'b0});
        put(8'h20);
        i_pitp_ctrl_model.start_cond();
        put({DUT_ADDR, 1'b1});
        for (int i = 0; i < 3; i++)
        begin
            i_pitp_ctrl_model.recv_byte(i < 2, d);
            chk_byte("read data", 8'(8'h11 * (i + 1)), d);
        end
        i_pitp_ctrl_model.stop_cond();
        chk_byte("read accesses", 8'(n0 + 3), 8'(n_acc));
        $display("test read_stream done");
    endtask

    // Every master code is refused, arms high-speed, and a stop disarms it
    task automatic t_hs_codes();
        logic ack;
        for (int c = 0; c < 8; c++)
        begin
            i_pitp_ctrl_model.start_cond();
            i_pitp_ctrl_model.send_byte(HS_MASTER_CODE | 8'(c), ack);
            chk_bit("code ack", 1'b0, ack);
            repeat (10) @(negedge clk_sys);
            chk_bit("hs armed", 1'b1, hs_active);
            i_pitp_ctrl_model.stop_cond();
            repeat (10) @(negedge clk_sys);
            chk_bit("hs after stop", 1'b0, hs_active);
        end
        $display("test hs_codes done");
    endtask

    task automatic t_hs_transfer();
        logic [7:0] d;
        logic ack;
        i_pitp_ctrl_model.start_cond();
        i_pitp_ctrl_model.send_byte(8'h0A, ack);
        chk_bit("code ack", 1'b0, ack);
        i_pitp_ctrl_model.set_speed(1'b1);
        i_pitp_ctrl_model.start_cond();
        put({DUT_ADDR, 1'b0});
        put(8'h60);
        put(8'h81);
        put(8'h7E);
        i_pitp_ctrl_model.start_cond();
        put({DUT_ADDR, 1'b0});
        put(8'h60);
        i_pitp_ctrl_model.start_cond();
        put({DUT_ADDR, 1'b1});
        i_pitp_ctrl_model.recv_byte(1'b1, d);
        chk_byte("hs read 0", 8'h81, d);
        i_pitp_ctrl_model.recv_byte(1'b0, d);
        chk_byte("hs read 1", 8'h7E, d);
        chk_bit("hs kept over restart", 1'b1, hs_active);
        i_pitp_ctrl_model.stop_cond();
        i_pitp_ctrl_model.set_speed(1'b0);
        repeat (10) @(negedge clk_sys);
        chk_bit("hs after stop", 1'b0, hs_active);
        i_pitp_ctrl_model.start_cond();
        put({DUT_ADDR, 1'b0});
        i_pitp_ctrl_model.stop_cond();
        $display("test hs_transfer done");
    endtask

    // Single place where the run ends
    task automatic report_and_stop();
        errors += i_pitp_ctrl_model.stalls;
        $display("comparisons %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // Tests need about 20k cycles; far beyond that means a hang
    initial
    begin
        repeat (90000) @(posedge clk_sys);
        errors++;
        $display("unexpected watchdog expected done seen hang");
        report_and_stop();
    end

    initial
    begin
        resetn = 1'b0;
        io_logic_supply_ok = 1'b1;
        boot_done = 1'b1;
        for (int i = 0; i < 3; i++)
            mem[8'h20 + i] = 8'(8'h11 * (i + 1));
        repeat (3) @(negedge clk_sys);
        resetn = 1'b1;
        repeat (10) @(negedge clk_sys);
        t_not_ready();
        t_addr_range();
        t_write_stream();
        t_read_stream();
        t_hs_codes();
        t_hs_transfer();
        report_and_stop();
    end
endmodule
